// [core/tcmp_params.svh]
// Constants for the tightly coupled memory port
`ifndef TCMP_PARAMS_SVH
`define TCMP_PARAMS_SVH
`define TCMP_ADDR_W        18
`define TCMP_DATA_W        32
`define TCMP_LANES_W       4
`define TCMP_WORD_LSB      2
`define TCMP_SIZE_ABSENT   4'h0
`define TCMP_SIZE_MIN      4'h3
`define TCMP_SIZE_MAX      4'hb
`define TCMP_LANES_NONE    4'h0
`define TCMP_LANES_ALL     4'hf
`define TCMP_LANES_HALF    4'h3
`define TCMP_LANES_BYTE    4'h1
`define TCMP_VEC_LOW       32'h0000_0000
`define TCMP_VEC_HIGH      32'hffff_0000
`endif

// [core/tcmp_pkg.sv]
// Types shared by the memory port
package tcmp_pkg;
  typedef enum logic [1:0] {
    TCMP_WORD,
    TCMP_HALF,
    TCMP_BYTE
  } tcmp_width_e;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [19:0] byte_addr;
    tcmp_width_e width;
    logic [31:0] wdata;
  } tcmp_req_s;
endpackage

// [core/tcmp_port.sv]
// Data and instruction tightly coupled memory port
`timescale 1ns/1ns
`include "tcmp_params.svh"
module tcmp_port #(
  parameter int ADDR_W = `TCMP_ADDR_W
) (
  input  wire logic                 mclk_in,
  input  wire logic                 reset_in,
  input  wire tcmp_pkg::tcmp_req_s  dreq_in,
  output logic                      dreq_ready_out,
  output logic [31:0]               drdata_out,
  output logic                      drdata_valid_out,
  input  wire logic [19:0]          ifetch_addr_in,
  input  wire logic                 ifetch_valid_in,
  input  wire logic                 itcm_boot_enable_in,
  input  wire logic                 high_vector_select_in,
  output logic                      itcm_enabled_out,
  output logic                      boot_from_itcm_out,
  output logic [31:0]               vector_base_out,
  output logic [ADDR_W-1:0]         dtcm_addr_out,
  output logic                      dtcm_chip_sel_out,
  input  wire logic [ADDR_W-1:0]    dtcm_dma_addr_in,
  input  wire logic                 dtcm_dma_enable_in,
  input  wire logic                 dtcm_dma_chip_sel_in,
  output logic                      dtcm_idle_out,
  output logic                      dtcm_write_not_read_out,
  input  wire logic [31:0]          dtcm_read_data_in,
  output logic                      dtcm_sequential_out,
  input  wire logic [3:0]           dtcm_size_cfg_in,
  input  wire logic                 dtcm_wait_in,
  output logic [3:0]                dtcm_byte_lanes_out,
  output logic [31:0]               dtcm_write_data_out,
  output logic [ADDR_W-1:0]         itcm_addr_out,
  output logic                      itcm_chip_sel_out
);
  import tcmp_pkg::*;

  if (ADDR_W != `TCMP_ADDR_W) begin : g_bad_addr_w
    $error("tcmp_port: address width must be 18");
  end

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_REQ,
    ST_WAIT
  } tcmp_state_e;

  function automatic logic [3:0] lanes_of(input tcmp_width_e w, input logic [1:0] lo);
    logic [3:0] base;
    base = `TCMP_LANES_ALL;
    case (w)
      TCMP_HALF: base = `TCMP_LANES_HALF << {lo[1], 1'b0};
      TCMP_BYTE: base = `TCMP_LANES_BYTE << lo;
      default:   base = `TCMP_LANES_ALL;
    endcase
    return base;
  endfunction

  tcmp_state_e        state_reg, state_next;
  logic [ADDR_W-1:0]  addr_reg, prev_addr_reg;
  logic               prev_valid_reg;
  logic               write_reg, seq_reg;
  logic [3:0]         lanes_reg;
  logic [31:0]        wdata_reg, rdata_reg;
  logic               rvalid_reg;
  logic [ADDR_W-1:0]  iaddr_reg;
  logic               itcm_en_reg, boot_reg, reset_seen_reg;

  wire logic              mem_present = (dtcm_size_cfg_in >= `TCMP_SIZE_MIN) &&
                                        (dtcm_size_cfg_in <= `TCMP_SIZE_MAX);
  wire logic [ADDR_W-1:0] req_word    = dreq_in.byte_addr[ADDR_W+`TCMP_WORD_LSB-1:`TCMP_WORD_LSB];
  wire logic [ADDR_W-1:0] fetch_word  = ifetch_addr_in[ADDR_W+`TCMP_WORD_LSB-1:`TCMP_WORD_LSB];
  wire logic              in_access   = (state_reg == ST_REQ) || (state_reg == ST_WAIT);
  wire logic              waited      = in_access && dtcm_wait_in;
  wire logic              take        = dreq_in.valid && mem_present && !waited;

  assign dreq_ready_out = mem_present && !waited;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (take) state_next = ST_REQ;
      ST_REQ,
      ST_WAIT: begin
        if (dtcm_wait_in) state_next = ST_WAIT;
        else if (take) state_next = ST_REQ;
        else state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // Request registers, held through wait cycles
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      state_reg      <= ST_IDLE;
      addr_reg       <= '0;
      prev_addr_reg  <= '0;
      prev_valid_reg <= 1'b0;
      write_reg      <= 1'b0;
      seq_reg        <= 1'b0;
      lanes_reg      <= `TCMP_LANES_NONE;
      wdata_reg      <= '0;
    end else begin
      state_reg <= state_next;
      if (take) begin
        addr_reg       <= req_word;
        write_reg      <= dreq_in.write;
        seq_reg        <= prev_valid_reg && (req_word == prev_addr_reg + 1'b1);
        lanes_reg      <= dreq_in.write ? lanes_of(dreq_in.width, dreq_in.byte_addr[`TCMP_WORD_LSB-1:0])
                                        : `TCMP_LANES_NONE;
        wdata_reg      <= dreq_in.wdata;
        prev_addr_reg  <= req_word;
        prev_valid_reg <= 1'b1;
      end else if (!waited) begin
        lanes_reg <= `TCMP_LANES_NONE;
        write_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rdata_reg  <= '0;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= in_access && !dtcm_wait_in && !write_reg;
      if (in_access && !dtcm_wait_in && !write_reg) rdata_reg <= dtcm_read_data_in;
    end
  end

  assign drdata_out       = rdata_reg;
  assign drdata_valid_out = rvalid_reg;

  assign dtcm_addr_out           = dtcm_dma_enable_in ? dtcm_dma_addr_in : addr_reg;
  assign dtcm_chip_sel_out       = dtcm_dma_enable_in ? (dtcm_dma_chip_sel_in | take) : take;
  assign dtcm_idle_out           = !(in_access && mem_present);
  assign dtcm_write_not_read_out = write_reg;
  assign dtcm_sequential_out     = (state_reg == ST_WAIT) ? 1'b1 : seq_reg;
  assign dtcm_byte_lanes_out     = lanes_reg;
  assign dtcm_write_data_out     = wdata_reg;

  // Boot straps caught on the first clock after reset release
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      reset_seen_reg <= 1'b0;
      itcm_en_reg    <= 1'b0;
      boot_reg       <= 1'b0;
      iaddr_reg      <= '0;
    end else begin
      if (!reset_seen_reg) begin
        reset_seen_reg <= 1'b1;
        itcm_en_reg    <= itcm_boot_enable_in;
        boot_reg       <= itcm_boot_enable_in && !high_vector_select_in;
      end
      if (ifetch_valid_in && itcm_en_reg) iaddr_reg <= fetch_word;
    end
  end

  assign itcm_enabled_out   = itcm_en_reg;
  assign boot_from_itcm_out = boot_reg;
  assign itcm_addr_out      = iaddr_reg;
  assign itcm_chip_sel_out  = ifetch_valid_in && itcm_en_reg;
  assign vector_base_out    = high_vector_select_in ? `TCMP_VEC_HIGH : `TCMP_VEC_LOW;

  property p_cs_leads;
    @(posedge mclk_in) disable iff (reset_in) take |=> (state_reg == ST_REQ);
  endproperty
  a_cs_leads: assert property (p_cs_leads) else $error("access did not follow chip select");

  property p_dma_addr;
    @(posedge mclk_in) disable iff (reset_in) dtcm_dma_enable_in |-> dtcm_addr_out == dtcm_dma_addr_in;
  endproperty
  a_dma_addr: assert property (p_dma_addr) else $error("dma address not routed");

  property p_dma_cs;
    @(posedge mclk_in) disable iff (reset_in)
      (dtcm_dma_enable_in && dtcm_dma_chip_sel_in) |-> dtcm_chip_sel_out;
  endproperty
  a_dma_cs: assert property (p_dma_cs) else $error("dma chip select lost");

  property p_idle;
    @(posedge mclk_in) disable iff (reset_in) (state_reg == ST_REQ && mem_present) |-> !dtcm_idle_out;
  endproperty
  a_idle: assert property (p_idle) else $error("idle high during access");

  property p_dir;
    @(posedge mclk_in) disable iff (reset_in) take |=> dtcm_write_not_read_out == $past(dreq_in.write);
  endproperty
  a_dir: assert property (p_dir) else $error("direction mismatch");

  sequence s_wait_cycle;
    in_access && dtcm_wait_in;
  endsequence
  property p_seq_wait;
    @(posedge mclk_in) disable iff (reset_in) s_wait_cycle |=> dtcm_sequential_out;
  endproperty
  a_seq_wait: assert property (p_seq_wait) else $error("sequential dropped in wait");

  property p_lanes_read;
    @(posedge mclk_in) disable iff (reset_in) !dtcm_write_not_read_out |-> dtcm_byte_lanes_out == `TCMP_LANES_NONE;
  endproperty
  a_lanes_read: assert property (p_lanes_read) else $error("lanes set without write");

  property p_wdata_hold;
    @(posedge mclk_in) disable iff (reset_in)
      s_wait_cycle |=> $stable(dtcm_write_data_out) && $stable(dtcm_byte_lanes_out);
  endproperty
  a_wdata_hold: assert property (p_wdata_hold) else $error("write data moved in wait");

  sequence s_byte_write;
    take && dreq_in.write && (dreq_in.width == TCMP_BYTE);
  endsequence
  property p_lanes_byte;
    @(posedge mclk_in) disable iff (reset_in) s_byte_write |=> $onehot(dtcm_byte_lanes_out);
  endproperty
  a_lanes_byte: assert property (p_lanes_byte) else $error("byte write lanes not one-hot");

  property p_wait_no_data;
    @(posedge mclk_in) disable iff (reset_in) s_wait_cycle |=> !drdata_valid_out;
  endproperty
  a_wait_no_data: assert property (p_wait_no_data) else $error("read data taken in a waited cycle");

  property p_absent_idle;
    @(posedge mclk_in) disable iff (reset_in) !mem_present |-> dtcm_idle_out && !dreq_ready_out;
  endproperty
  a_absent_idle: assert property (p_absent_idle) else $error("absent memory not idle");

  property p_itcm_addr;
    @(posedge mclk_in) disable iff (reset_in)
      (ifetch_valid_in && itcm_enabled_out) |=> itcm_addr_out == $past(fetch_word);
  endproperty
  a_itcm_addr: assert property (p_itcm_addr) else $error("fetch word address not presented");

  property p_vec_low;
    @(posedge mclk_in) disable iff (reset_in) !high_vector_select_in |-> vector_base_out == `TCMP_VEC_LOW;
  endproperty
  a_vec_low: assert property (p_vec_low) else $error("low vector base wrong");
endmodule

// [testbench/tcmp_sram_model.sv]
// Behavioural data memory with commanded wait states
`timescale 1ns/1ns
module tcmp_sram_model (
  input  wire logic        mclk_in,
  input  wire logic        idle_in,
  input  wire logic [17:0] addr_in,
  input  wire logic        wnr_in,
  input  wire logic [3:0]  lanes_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic [3:0]  stall_in,
  output logic             wait_out,
  output logic [31:0]      rdata_out
);
  logic [31:0] mem [16];
  logic [3:0]  cnt_reg = 4'h0;
  logic [31:0] last_reg = 32'h0;
  assign wait_out = !idle_in && (cnt_reg < stall_in);
  // Unserved cycles show inverted data
  assign rdata_out = (!idle_in && !wait_out) ? mem[addr_in[3:0]] : ~last_reg;
  always @(posedge mclk_in) begin
    cnt_reg <= wait_out ? cnt_reg + 4'h1 : 4'h0;
    last_reg <= rdata_out;
    for (int b = 0; b < 4; b++)
      if (!idle_in && !wait_out && wnr_in && lanes_in[b]) mem[addr_in[3:0]][8*b +: 8] <= wdata_in[8*b +: 8];
  end
endmodule

// [testbench/testbench.sv]
// Self-checking bench for the memory port
`timescale 1ns/1ns
module testbench;
  import tcmp_pkg::*;
  logic        mclk_in = 0, reset_in = 1, ifetch_valid_in = 0, itcm_boot_enable_in = 1;
  logic        high_vector_select_in = 0, dtcm_dma_enable_in = 0, dtcm_dma_chip_sel_in = 0;
  logic        dreq_ready_out, drdata_valid_out, itcm_enabled_out, boot_from_itcm_out, dtcm_chip_sel_out;
  logic        dtcm_idle_out, dtcm_write_not_read_out, dtcm_sequential_out, dtcm_wait_in, itcm_chip_sel_out;
  logic [3:0]  dtcm_size_cfg_in = 4'h3, stall = 4'h0, dtcm_byte_lanes_out;
  logic [17:0] dtcm_dma_addr_in = 18'h0, dtcm_addr_out, itcm_addr_out, prev = 18'h0;
  logic [19:0] ifetch_addr_in = 20'h0;
  logic [31:0] drdata_out, vector_base_out, dtcm_read_data_in, dtcm_write_data_out;
  tcmp_req_s   dreq_in = '0;
  int          n_errors = 0, comparisons = 0;
  always #50 mclk_in = ~mclk_in;
  tcmp_port tcmp_port_i (
    .mclk_in                 (mclk_in),
    .reset_in                (reset_in),
    .dreq_in                 (dreq_in),
    .dreq_ready_out          (dreq_ready_out),
    .drdata_out              (drdata_out),
    .drdata_valid_out        (drdata_valid_out),
    .ifetch_addr_in          (ifetch_addr_in),
    .ifetch_valid_in         (ifetch_valid_in),
    .itcm_boot_enable_in     (itcm_boot_enable_in),
    .high_vector_select_in   (high_vector_select_in),
    .itcm_enabled_out        (itcm_enabled_out),
    .boot_from_itcm_out      (boot_from_itcm_out),
    .vector_base_out         (vector_base_out),
    .dtcm_addr_out           (dtcm_addr_out),
    .dtcm_chip_sel_out       (dtcm_chip_sel_out),
    .dtcm_dma_addr_in        (dtcm_dma_addr_in),
    .dtcm_dma_enable_in      (dtcm_dma_enable_in),
    .dtcm_dma_chip_sel_in    (dtcm_dma_chip_sel_in),
    .dtcm_idle_out           (dtcm_idle_out),
    .dtcm_write_not_read_out (dtcm_write_not_read_out),
    .dtcm_read_data_in       (dtcm_read_data_in),
    .dtcm_sequential_out     (dtcm_sequential_out),
    .dtcm_size_cfg_in        (dtcm_size_cfg_in),
    .dtcm_wait_in            (dtcm_wait_in),
    .dtcm_byte_lanes_out     (dtcm_byte_lanes_out),
    .dtcm_write_data_out     (dtcm_write_data_out),
    .itcm_addr_out           (itcm_addr_out),
    .itcm_chip_sel_out       (itcm_chip_sel_out)
  );
  tcmp_sram_model tcmp_sram_model_i (.mclk_in, .idle_in(dtcm_idle_out), .addr_in(dtcm_addr_out),
    .wnr_in(dtcm_write_not_read_out), .lanes_in(dtcm_byte_lanes_out), .wdata_in(dtcm_write_data_out),
    .stall_in(stall), .wait_out(dtcm_wait_in), .rdata_out(dtcm_read_data_in));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One transfer, judged cycle by cycle
  task automatic access(input logic wr, input logic [19:0] a, input tcmp_width_e w,
                        input logic [31:0] d, input logic [3:0] st);
    logic [3:0] ln;
    logic       sq;
    int         i;
    ln = !wr ? 4'h0 : w == TCMP_WORD ? 4'hf : w == TCMP_HALF ? 4'h3 << (2 * a[1]) : 4'h1 << a[1:0];
    sq = a[19:2] == prev + 18'h1;
    prev = a[19:2];
    @(negedge mclk_in);
    stall = st;
    dreq_in = '{1'b1, wr, a, w, d};
    #10;
    for (i = 0; i < 20 && dreq_ready_out !== 1'b1; i++) @(negedge mclk_in);
    if (i == 20) begin
      n_errors++;
      conclude();
    end
    check(dtcm_chip_sel_out, 1);
    @(negedge mclk_in);
    dreq_in.valid = 0;
    check(dtcm_addr_out, a[19:2]);
    check(dtcm_write_not_read_out, wr);
    check(dtcm_idle_out, 0);
    for (i = 0; i <= st; i++) begin
      check(dtcm_byte_lanes_out, ln);
      if (wr) check(dtcm_write_data_out, d);
      if (i == 0) check(dtcm_sequential_out, sq);
      else check(dtcm_sequential_out, 1);
      if (i < st) check(dreq_ready_out, 0);
      @(negedge mclk_in);
    end
    check(dtcm_idle_out, 1);
    if (!wr) check(drdata_out, d);
    if (!wr) check(drdata_valid_out, 1);
  endtask
  task automatic t_straps;
    check(itcm_enabled_out, 1);
    check(boot_from_itcm_out, 1);
    check(vector_base_out, 32'h0);
    high_vector_select_in = 1;
    ifetch_valid_in = 1;
    ifetch_addr_in = 20'h00abc;
    @(negedge mclk_in);
    check(vector_base_out, 32'hffff0000);
    check(itcm_chip_sel_out, 1);
    check(itcm_addr_out, 18'h002af);
    ifetch_valid_in = 0;
  endtask
  task automatic t_dma;
    @(negedge mclk_in);
    dtcm_dma_enable_in = 1;
    dtcm_dma_chip_sel_in = 1;
    dtcm_dma_addr_in = 18'h2abcd;
    #10 check(dtcm_addr_out, 18'h2abcd);
    check(dtcm_chip_sel_out, 1);
    @(negedge mclk_in);
    dtcm_dma_chip_sel_in = 0;
    #10 check(dtcm_chip_sel_out, 0);
    @(negedge mclk_in);
    dreq_in = '{1'b1, 1'b0, 20'h00020, TCMP_WORD, 32'h0};
    #10 check(dtcm_chip_sel_out, 1);
    check(dtcm_addr_out, 18'h2abcd);
    @(negedge mclk_in);
    dreq_in.valid = 0;
    dtcm_dma_enable_in = 0;
    #10 check(dtcm_addr_out, 18'h8);
    @(negedge mclk_in);
  endtask
  // Absent and reserved sizes refuse requests
  task automatic t_absent;
    logic [3:0] bad [4];
    bad = '{4'h0, 4'h1, 4'h2, 4'hc};
    foreach (bad[k]) begin
      @(negedge mclk_in);
      dtcm_size_cfg_in = bad[k];
      dreq_in = '{1'b1, 1'b0, 20'h4, TCMP_WORD, 32'h0};
      #10 check(dreq_ready_out, 0);
      check(dtcm_chip_sel_out, 0);
      @(negedge mclk_in);
      check(dtcm_idle_out, 1);
      dreq_in.valid = 0;
    end
    dtcm_size_cfg_in = 4'h3;
  endtask
  initial begin
    repeat (20) @(negedge mclk_in);
    reset_in = 0;
    repeat (3) @(negedge mclk_in);
    t_straps();
    access(1, 20'h00010, TCMP_WORD, 32'h11223344, 2);
    access(1, 20'h00014, TCMP_WORD, 32'h55667788, 0);
    access(1, 20'h00013, TCMP_BYTE, 32'haabbccdd, 0);
    access(1, 20'h00010, TCMP_HALF, 32'h9999eeff, 1);
    access(1, 20'h00016, TCMP_HALF, 32'h12345678, 0);
    access(0, 20'h00010, TCMP_WORD, 32'haa22eeff, 1);
    access(0, 20'h00014, TCMP_WORD, 32'h12347788, 0);
    t_dma();
    t_absent();
    conclude();
  end
endmodule
